// *** enc_snap_pkg.sv ***
// Constants shared by the encoder snapshot channel and its helper modules.
package enc_snap_pkg;

    // Clock and timing figures.
    localparam int CLK_PERIOD_NS = 5;
    localparam int US_NS = 1000;
    localparam int US_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam int PULSE_NS = 20;
    localparam int PULSE_CYCLES = (PULSE_NS / CLK_PERIOD_NS < 1) ? 1 : PULSE_NS / CLK_PERIOD_NS;
    localparam int LATCH_NS = 20;
    localparam int LATCH_CYCLES = LATCH_NS / CLK_PERIOD_NS;

    // Register offsets (byte addresses, one word each).
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_RELOAD = 8'h08;
    localparam logic [7:0] OFS_COMPARE = 8'h0c;
    localparam logic [7:0] OFS_SNAP_CFG = 8'h10;
    localparam logic [7:0] OFS_SNAP_SET = 8'h14;
    localparam logic [7:0] OFS_COMMAND = 8'h18;
    localparam logic [7:0] OFS_EXT_ROUTE = 8'h1c;
    localparam logic [7:0] OFS_TICK_PERIOD = 8'h20;
    localparam logic [7:0] OFS_SNAP_STATUS = 8'h24;
    localparam logic [7:0] OFS_SNAP_COUNT = 8'h28;
    localparam logic [7:0] OFS_SNAP_TIME = 8'h2c;
    localparam logic [7:0] OFS_SNAP_REASON = 8'h30;
    localparam logic [7:0] OFS_SNAP_POP = 8'h34;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h38;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h3c;
    localparam logic [7:0] OFS_TIMESTAMP = 8'h40;

    // Control register fields.
    localparam int CTRL_CLK_POS = 0;
    localparam int CTRL_IDX_POS = 2;
    localparam int CTRL_OM_POS = 4;
    localparam int CTRL_PEER_PRELOAD_POS = 6;
    localparam int CTRL_RUN_POS = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Snapshot trigger mask bits; the disarm bit sits this far above its enable.
    localparam int DISARM_SHIFT = 16;
    localparam logic [7:0] TRIG_MATCH0 = 8'h01;
    localparam logic [7:0] TRIG_IDX_RISE = 8'h08;
    localparam logic [7:0] TRIG_IDX_FALL = 8'h10;
    localparam logic [7:0] TRIG_EXT_FALL = 8'h20;
    localparam logic [7:0] TRIG_EXT_RISE = 8'h40;
    localparam logic [7:0] TRIG_SOFT = 8'h80;
    localparam logic [7:0] TRIG_IMPL = 8'h79;

    // Command bits, interrupt bits and other reset values.
    localparam int CMD_PRELOAD_POS = 0;
    localparam int CMD_SNAP_POS = 1;
    localparam int IRQ_SNAP_POS = 0;
    localparam int IRQ_OVF_POS = 1;
    localparam int DIO_LINES = 48;
    localparam logic [31:0] TICK_PERIOD_RESET = 32'h000186a0;
    localparam int QUEUE_DEPTH_LOG2 = 4;
    localparam int ENTRY_WIDTH = 72;

    // Clock source, index source and output mode encodings.
    typedef enum logic [1:0] {
        CLK_QUAD_X4 = 2'b00,
        CLK_INT_1MHZ = 2'b01
    } clk_src_type;
    typedef enum logic [1:0] {
        IDX_TERMINAL = 2'b00,
        IDX_TICK = 2'b01,
        IDX_PEER = 2'b10
    } idx_src_type;
    typedef enum logic [1:0] {
        OM_OFF = 2'b00,
        OM_PULSE_ON_CAPTURE = 2'b01,
        OM_NOT_ZERO = 2'b10
    } out_mode_type;

endpackage

// *** quad_decoder.sv ***
// Four-times quadrature decoder producing a step pulse and a direction.
`timescale 1ns/1ps
module quad_decoder (
    // Clock and reset.
    input  wire logic sys_clk,
    input  wire logic srst,
    // Synchronised encoder phases.
    input  wire logic phase_a,
    input  wire logic phase_b,
    // Step pulse and direction, up when high.
    output logic      step,
    output logic      count_up
);

    logic prev_a;
    logic prev_b;
    wire  a_moved = phase_a ^ prev_a;
    wire  b_moved = phase_b ^ prev_b;

    // Exactly one phase changing is a valid step; both at once is dropped.
    assign step = a_moved ^ b_moved; // RULE10 RULE17
    assign count_up = phase_a ^ prev_b; // RULE17

    // Remember the phases of the previous cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end else begin
            prev_a <= phase_a;
            prev_b <= phase_b;
        end
    end

endmodule

// *** snap_queue.sv ***
// Snapshot queue: a small memory with registered read data and pointers.
`timescale 1ns/1ps
module snap_queue (
    // Clock and reset.
    input  wire logic                                      sys_clk,
    input  wire logic                                      srst,
    // Fill side.
    input  wire logic                                      push,
    input  wire logic [enc_snap_pkg::ENTRY_WIDTH-1:0]      push_data,
    // Drain side.
    input  wire logic                                      pop,
    output logic      [enc_snap_pkg::ENTRY_WIDTH-1:0]      head_data,
    // Fill level.
    output logic      [enc_snap_pkg::QUEUE_DEPTH_LOG2:0]   level
);

    localparam int AW = enc_snap_pkg::QUEUE_DEPTH_LOG2;
    logic [enc_snap_pkg::ENTRY_WIDTH-1:0] mem [0:(1<<AW)-1];
    logic [AW-1:0] head;
    logic [AW-1:0] tail;
    wire  do_pop = pop && (level != '0);
    wire  do_push = push && (level[AW] == 1'b0);
    wire  [AW-1:0] next_head = do_pop ? AW'(head + 1'b1) : head;

    // The read address looks ahead so the head entry is ready a cycle after a pop.
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem[tail] <= push_data;
        end
        head_data <= mem[next_head];
    end

    // Pointers and fill level; a push into a full queue is dropped.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            head <= '0;
            tail <= '0;
            level <= '0;
        end else begin
            head <= next_head;
            if (do_push) begin
                tail <= AW'(tail + 1'b1);
            end
            level <= (AW+1)'(level + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop});
        end
    end

endmodule

// *** encoder_counter_snapshot.sv ***
// Encoder counter channel that queues count and timestamp snapshots.
//
// Overview of operation
// RULE1 - Snapshot stores count paired with timestamp.
// RULE2 - Selectable index source, tick generator, rise trigger.
// RULE3 - Index terminal feeds index; latch within 20ns.
// RULE4 - Disarm bit sixteen above clears enable.
// RULE5 - Masked set write enables selected triggers.
// RULE6 - Capture pulse output lasts 20 ns.
// RULE7 - Output pulse only when capture occurs.
// RULE8 - Compare match triggers; compare rewritable anytime.
// RULE9 - Peer output can preload a one-shot.
// RULE10 - Quadrature mode counts every phase transition.
// RULE11 - Shared external input captures simultaneously, 20ns.
// RULE12 - External input routable from lines 0-47.
// RULE13 - External fall 0x20, rise 0x40.
// RULE14 - Snapshots queue with reason until read.
// RULE15 - Soft preload loads reload value immediately.
// RULE16 - Timestamp advances every microsecond, shared timing.
// RULE17 - Decoder direction by phase order, ignores invalid.
`timescale 1ns/1ps
module encoder_counter_snapshot (
    // Clock and reset.
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // Register port.
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    // Encoder and sensor pins.
    input  wire logic        quad_a,
    input  wire logic        quad_b,
    input  wire logic        index_terminal_pos,
    input  wire logic [47:0] dio_in,
    // Output of another channel, same clock.
    input  wire logic        peer_output,
    // Channel output and interrupt.
    output logic             channel_output,
    output logic             irq
);

    // Registers written by software.
    logic [7:0]  ctrl;
    logic [31:0] first_reload_value;
    logic [31:0] first_compare_value;
    logic [31:0] snap_cfg;
    logic [5:0]  ext_route;
    logic [31:0] tick_period;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;

    // Channel state.
    logic [31:0] count;
    logic [31:0] timestamp;
    logic [7:0]  us_div;
    logic [31:0] tick_div;
    logic        tick;
    logic [2:0]  pulse_left;
    logic [1:0]  sync_a;
    logic [1:0]  sync_b;
    logic [1:0]  sync_idx;
    logic [1:0]  sync_ext;
    logic        prev_idx;
    logic        prev_ext;
    logic        prev_match;
    logic        prev_peer;
    logic        soft_snap;
    logic        soft_snap_req;

    // Edge helpers used for every trigger source except the software snapshot.
    function automatic logic rose(input logic prev, input logic now);
        rose = now & ~prev;
    endfunction
    function automatic logic fell(input logic prev, input logic now);
        fell = prev & ~now;
    endfunction

    // Register decode.
    wire wr_ctrl = reg_write && (reg_addr == enc_snap_pkg::OFS_CTRL);
    wire wr_reload = reg_write && (reg_addr == enc_snap_pkg::OFS_RELOAD);
    wire wr_compare = reg_write && (reg_addr == enc_snap_pkg::OFS_COMPARE);
    wire wr_cfg = reg_write && (reg_addr == enc_snap_pkg::OFS_SNAP_CFG);
    wire wr_set = reg_write && (reg_addr == enc_snap_pkg::OFS_SNAP_SET);
    wire wr_cmd = reg_write && (reg_addr == enc_snap_pkg::OFS_COMMAND);
    wire wr_route = reg_write && (reg_addr == enc_snap_pkg::OFS_EXT_ROUTE);
    wire wr_tick = reg_write && (reg_addr == enc_snap_pkg::OFS_TICK_PERIOD);
    wire wr_pop = reg_write && (reg_addr == enc_snap_pkg::OFS_SNAP_POP);
    wire wr_irq_clr = reg_write && (reg_addr == enc_snap_pkg::OFS_IRQ_STATUS);
    wire wr_irq_mask = reg_write && (reg_addr == enc_snap_pkg::OFS_IRQ_MASK);
    wire soft_preload = wr_cmd && reg_wdata[enc_snap_pkg::CMD_PRELOAD_POS];

    // Control fields.
    wire [1:0] clk_sel = ctrl[enc_snap_pkg::CTRL_CLK_POS +: 2];
    wire [1:0] idx_sel = ctrl[enc_snap_pkg::CTRL_IDX_POS +: 2];
    wire [1:0] om_sel = ctrl[enc_snap_pkg::CTRL_OM_POS +: 2];
    wire peer_preload_en = ctrl[enc_snap_pkg::CTRL_PEER_PRELOAD_POS];
    wire run = ctrl[enc_snap_pkg::CTRL_RUN_POS];

    // Microsecond enable from the divider; every channel reset together stays aligned.
    wire us_tick = (us_div == 8'(enc_snap_pkg::US_CYCLES - 1));

    // Index source select; local sources skip the synchroniser.
    logic index_input;
    always_comb begin
        case (idx_sel)
            enc_snap_pkg::IDX_TERMINAL: index_input = sync_idx[1]; // RULE3
            enc_snap_pkg::IDX_TICK:     index_input = tick; // RULE2
            enc_snap_pkg::IDX_PEER:     index_input = peer_output;
            default:                    index_input = sync_idx[1];
        endcase
    end

    // The routed line is picked first and then synchronised; a route change may
    // produce one spurious edge, so software reroutes with triggers disabled.
    wire ext_raw = (ext_route < 6'(enc_snap_pkg::DIO_LINES)) ? dio_in[ext_route] : 1'b0; // RULE12
    wire external_trigger_input = sync_ext[1];

    // Quadrature decode of the synchronised phases.
    logic quad_step;
    logic quad_up;
    quad_decoder u_quad (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .phase_a  (sync_a[1]),
        .phase_b  (sync_b[1]),
        .step     (quad_step),
        .count_up (quad_up)
    );

    // Trigger events of this cycle.
    wire match_now = (count == first_compare_value);
    wire [7:0] events = {
        soft_snap,
        rose(prev_ext, external_trigger_input), // RULE13 RULE11
        fell(prev_ext, external_trigger_input), // RULE13 RULE11
        fell(prev_idx, index_input),
        rose(prev_idx, index_input), // RULE2 RULE3
        2'b00,
        rose(prev_match, match_now) // RULE8
    };
    wire [7:0] armed = snap_cfg[7:0] & enc_snap_pkg::TRIG_IMPL;
    wire [7:0] reason = events & (armed | enc_snap_pkg::TRIG_SOFT);
    wire capture = (reason != 8'h00);

    // Triggers that fired with their disarm bit set are cleared.
    wire [7:0] disarm = reason[7:0] & snap_cfg[enc_snap_pkg::DISARM_SHIFT +: 8]; // RULE4

    // Counter next value: soft preload, peer preload, then counting.
    wire peer_rise = peer_preload_en && rose(prev_peer, peer_output);
    logic [31:0] next_count;
    always_comb begin
        next_count = count;
        if (soft_preload) begin
            next_count = first_reload_value; // RULE15
        end else if (peer_rise) begin
            next_count = first_reload_value; // RULE9
        end else if (run) begin
            case (clk_sel)
                enc_snap_pkg::CLK_QUAD_X4: begin
                    if (quad_step) begin
                        next_count = quad_up ? count + 32'h1 : count - 32'h1; // RULE10 RULE17
                    end
                end
                enc_snap_pkg::CLK_INT_1MHZ: begin
                    if (us_tick && count != 32'h0) begin
                        next_count = count - 32'h1; // RULE9
                    end
                end
                default: next_count = count;
            endcase
        end
    end

    // Snapshot queue; an entry is count, timestamp and reason.
    logic [enc_snap_pkg::ENTRY_WIDTH-1:0] head_entry;
    logic [enc_snap_pkg::QUEUE_DEPTH_LOG2:0] queue_level;
    wire queue_full = queue_level[enc_snap_pkg::QUEUE_DEPTH_LOG2];
    snap_queue u_queue (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .push      (capture),
        .push_data ({reason, timestamp, count}), // RULE1 RULE14
        .pop       (wr_pop),
        .head_data (head_entry),
        .level     (queue_level)
    );

    // Interrupt events and output.
    wire [1:0] irq_events = {capture && queue_full, capture};
    assign irq = |(irq_status & irq_mask);

    // Read data selection.
    logic [31:0] read_mux;
    always_comb begin
        case (reg_addr)
            enc_snap_pkg::OFS_CTRL:        read_mux = {24'h0, ctrl};
            enc_snap_pkg::OFS_COUNT:       read_mux = count;
            enc_snap_pkg::OFS_RELOAD:      read_mux = first_reload_value;
            enc_snap_pkg::OFS_COMPARE:     read_mux = first_compare_value;
            enc_snap_pkg::OFS_SNAP_CFG:    read_mux = snap_cfg;
            enc_snap_pkg::OFS_EXT_ROUTE:   read_mux = {26'h0, ext_route};
            enc_snap_pkg::OFS_TICK_PERIOD: read_mux = tick_period;
            enc_snap_pkg::OFS_SNAP_STATUS: read_mux = {27'h0, queue_level};
            enc_snap_pkg::OFS_SNAP_COUNT:  read_mux = head_entry[31:0];
            enc_snap_pkg::OFS_SNAP_TIME:   read_mux = head_entry[63:32];
            enc_snap_pkg::OFS_SNAP_REASON: read_mux = {24'h0, head_entry[71:64]}; // RULE14
            enc_snap_pkg::OFS_IRQ_STATUS:  read_mux = {30'h0, irq_status};
            enc_snap_pkg::OFS_IRQ_MASK:    read_mux = {30'h0, irq_mask};
            enc_snap_pkg::OFS_TIMESTAMP:   read_mux = timestamp;
            default:                       read_mux = 32'h0;
        endcase
    end

    // Read data stand in the cycle after the strobe only.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_read ? read_mux : 32'h0;
        end
    end

    // Plain configuration registers.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl <= enc_snap_pkg::CTRL_RESET;
            first_reload_value <= 32'h0;
            first_compare_value <= 32'h0;
            ext_route <= 6'h00;
            tick_period <= enc_snap_pkg::TICK_PERIOD_RESET;
            irq_mask <= 2'h0;
        end else begin
            if (wr_ctrl) ctrl <= reg_wdata[7:0];
            if (wr_reload) first_reload_value <= reg_wdata;
            if (wr_compare) first_compare_value <= reg_wdata; // RULE8
            if (wr_route) ext_route <= reg_wdata[5:0];
            if (wr_tick) tick_period <= reg_wdata;
            if (wr_irq_mask) irq_mask <= reg_wdata[1:0];
        end
    end

    // Trigger configuration: plain write, masked set write, self disarm.
    // A software write in the same cycle as a disarm wins, being the newer intent.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            snap_cfg <= 32'h0;
        end else if (wr_cfg) begin
            snap_cfg <= reg_wdata;
        end else if (wr_set) begin
            snap_cfg <= snap_cfg | reg_wdata; // RULE5
        end else begin
            snap_cfg[7:0] <= snap_cfg[7:0] & ~disarm; // RULE4
        end
    end

    // Sticky interrupt status; a new event wins over a clear in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= (irq_status & ~(wr_irq_clr ? reg_wdata[1:0] : 2'h0)) | irq_events;
        end
    end

    // Software snapshot request, taken two cycles after the command write.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            soft_snap_req <= 1'b0;
            soft_snap <= 1'b0;
        end else begin
            soft_snap_req <= wr_cmd && reg_wdata[enc_snap_pkg::CMD_SNAP_POS];
            soft_snap <= soft_snap_req;
        end
    end

    // Pin synchronisers: two flops on each pin; the external line passes the route select first.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync_a <= 2'b00;
            sync_b <= 2'b00;
            sync_idx <= 2'b00;
            sync_ext <= 2'b00;
        end else begin
            sync_a <= {sync_a[0], quad_a};
            sync_b <= {sync_b[0], quad_b};
            sync_idx <= {sync_idx[0], index_terminal_pos}; // RULE3
            sync_ext <= {sync_ext[0], ext_raw}; // RULE11
        end
    end

    // Edge history of the index, external, match and peer inputs.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prev_idx <= 1'b0;
            prev_ext <= 1'b0;
            prev_match <= 1'b0;
            prev_peer <= 1'b0;
        end else begin
            prev_idx <= index_input;
            prev_ext <= external_trigger_input;
            prev_match <= match_now;
            prev_peer <= peer_output;
        end
    end

    // Counter register; the snapshot above reads it in the capture cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count <= 32'h0;
        end else begin
            count <= next_count;
        end
    end

    // Microsecond divider and free running timestamp.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            us_div <= 8'h00;
            timestamp <= 32'h0;
        end else if (us_tick) begin
            us_div <= 8'h00;
            timestamp <= timestamp + 32'h1; // RULE16
        end else begin
            us_div <= us_div + 8'h01;
        end
    end

    // Periodic tick generator: a one-cycle high every tick_period microseconds.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tick_div <= 32'h0;
            tick <= 1'b0;
        end else begin
            tick <= 1'b0;
            if (us_tick) begin
                if (tick_div + 32'h1 >= tick_period) begin
                    tick_div <= 32'h0;
                    tick <= 1'b1; // RULE2
                end else begin
                    tick_div <= tick_div + 32'h1;
                end
            end
        end
    end

    // Capture pulse timer; it restarts only on a capture, never on a held match.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pulse_left <= 3'h0;
        end else if (capture) begin
            pulse_left <= 3'(enc_snap_pkg::PULSE_CYCLES); // RULE6 RULE7
        end else if (pulse_left != 3'h0) begin
            pulse_left <= pulse_left - 3'h1;
        end
    end

    // Channel output per mode, registered so it is glitch free at the pin.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            channel_output <= 1'b0;
        end else begin
            case (om_sel)
                enc_snap_pkg::OM_PULSE_ON_CAPTURE:
                    channel_output <= capture || (pulse_left > 3'h1); // RULE6 RULE7
                enc_snap_pkg::OM_NOT_ZERO:
                    channel_output <= (next_count != 32'h0); // RULE9
                default:
                    channel_output <= 1'b0;
            endcase
        end
    end

endmodule

// *** enc_snap_monitor.sv ***
// Port checker for the encoder snapshot channel.
`timescale 1ns/1ps
module enc_snap_checker (
    // Clock, reset and register port.
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    // Outputs.
    input wire logic        channel_output,
    input wire logic        irq
);
    logic [7:0] ctrl;
    logic [1:0] mask;
    // Shadows of control and mask, so checks know the mode without peeking inside.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ctrl <= 8'h00;
            mask <= 2'h0;
        end else if (reg_write && reg_addr == 8'h00) begin
            ctrl <= reg_wdata[7:0];
        end else if (reg_write && reg_addr == 8'h3c) begin
            mask <= reg_wdata[1:0];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence pulse_rise;
        ctrl[5:4] == 2'h1 && $rose(channel_output);
    endsequence
    sequence pulse_body;
        channel_output [*4] ##1 !channel_output;
    endsequence
    a_pulse_four: assert property (pulse_rise |-> pulse_body)
        else $error("capture pulse width wrong");
    a_pulse_quiet: assert property ((ctrl[5:4] == 2'h0) [*6] |-> !channel_output)
        else $error("output high with mode off");
    a_rdata_idle: assert property (reg_rdata != 32'h0 |-> $past(reg_read))
        else $error("read data outside read slot");
    a_rdata_unmap: assert property ($past(reg_read) && $past(reg_addr) > 8'h40
        |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
    a_reset_quiet: assert property ($past(srst) |-> !channel_output && !irq)
        else $error("outputs not cleared by reset");
    a_irq_masked: assert property (irq |-> mask != 2'h0)
        else $error("interrupt with all sources masked");
    a_mask_back: assert property ($past(reg_read) && $past(reg_addr) == 8'h3c
        |-> reg_rdata[1:0] == $past(mask)) else $error("mask readback wrong");
    a_ctrl_back: assert property ($past(reg_read) && $past(reg_addr) == 8'h00
        |-> reg_rdata[7:0] == $past(ctrl)) else $error("control readback wrong");
endmodule
bind encoder_counter_snapshot enc_snap_checker i_enc_snap_checker (.sys_clk(sys_clk),
    .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .channel_output(channel_output),
    .irq(irq));

// *** enc_partner.sv ***
// Quadrature encoder model that steps its phases on command.
`timescale 1ns/1ps
module enc_partner (
    // Clock and step commands.
    input wire logic sys_clk,
    input wire logic fwd,
    input wire logic bwd,
    input wire logic jump,
    // Encoder phases.
    output logic     quad_a,
    output logic     quad_b
);
    logic [1:0] ph = 2'h0;
    // A jump of two states flips both phases at once, an illegal move.
    always @(posedge sys_clk) begin
        ph <= ph + 2'(fwd) - 2'(bwd) + {jump, 1'b0};
    end
    // Gray coding, phase a leading when moving forward.
    assign quad_b = ph[1];
    assign quad_a = ph[1] ^ ph[0];
endmodule

// *** encoder_counter_snapshot_test.sv ***
// Self-checking bench for the encoder snapshot channel.
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module encoder_counter_snapshot_test;
    logic        sys_clk = 0;
    logic        srst = 1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 0;
    logic        reg_read = 0;
    logic [31:0] reg_rdata;
    logic        quad_a, quad_b, channel_output, irq;
    logic        fwd = 0, bwd = 0, jump = 0, prev_out = 0;
    logic        index_terminal_pos = 0;
    logic        peer_output = 0;
    logic [47:0] dio_in = {48{1'b1}};
    logic [7:0]  rnd = 8'h47;
    logic [31:0] cnt = 32'h0, d;
    logic [39:0] q[$];
    int          failures = 0, n_checks = 0, cyc = 0, n_pulse = 0;
    encoder_counter_snapshot i_encoder_counter_snapshot (.sys_clk(sys_clk), .srst(srst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
        .reg_read(reg_read), .reg_rdata(reg_rdata), .quad_a(quad_a), .quad_b(quad_b),
        .index_terminal_pos(index_terminal_pos), .dio_in(dio_in),
        .peer_output(peer_output), .channel_output(channel_output), .irq(irq));
    enc_partner i_enc_partner (.sys_clk(sys_clk), .fwd(fwd), .bwd(bwd), .jump(jump),
        .quad_a(quad_a), .quad_b(quad_b));
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1;
        @(posedge sys_clk);
        reg_write <= 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_read <= 1;
        @(posedge sys_clk);
        reg_read <= 0;
        #1 d = reg_rdata;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // Steps are spaced well apart so the pin synchronisers see every state.
    task automatic mv(input int n);
        repeat (n < 0 ? -n : n) begin
            @(posedge sys_clk);
            fwd <= n > 0;
            bwd <= n < 0;
            @(posedge sys_clk);
            fwd <= 0;
            bwd <= 0;
            wait_cyc(6);
        end
        cnt = cnt + n;
    endtask
    task automatic pop_check();
        rd(8'h30);
        `CHK(d[7:0], q[0][39:32])
        rd(8'h28);
        `CHK(d, q[0][31:0])
        void'(q.pop_front());
        wr(8'h34, 32'h1);
    endtask
    task automatic summarize();
        if (failures == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Counts output pulses and cuts a hung run short.
    always @(posedge sys_clk) begin
        cyc++;
        prev_out <= channel_output;
        if (channel_output === 1'b1 && prev_out === 1'b0)
            n_pulse++;
        if (cyc == 20000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        wait_cyc(4);
        srst <= 0;
        rd(8'h20);
        `CHK(d, 32'h000186a0)
        rd(8'h44);
        `CHK(d, 32'h0)
        wr(8'h00, 32'h90);
        wr(8'h3c, 32'h1);
        rd(8'h00);
        `CHK(d, 32'h90)
        rnd = lfsr(rnd);
        mv(int'(rnd[3:0]) + 5);
        mv(-3);
        @(posedge sys_clk);
        jump <= 1;
        @(posedge sys_clk);
        jump <= 0;
        wait_cyc(8);
        rd(8'h04);
        `CHK(d, cnt)
        rnd = lfsr(rnd);
        cnt = {24'h000001, rnd};
        wr(8'h08, cnt);
        wr(8'h18, 32'h1);
        rd(8'h04);
        `CHK(d, cnt)
        wr(8'h10, 32'h1);
        wr(8'h14, 32'h00080008);
        rd(8'h10);
        `CHK(d, 32'h00080009)
        index_terminal_pos <= 1;
        wait_cyc(10);
        q.push_back({8'h08, cnt});
        rd(8'h38);
        `CHK(d[0], 1'b1)
        `CHK(irq, 1'b1)
        wr(8'h38, 32'h1);
        #1 `CHK(irq, 1'b0)
        index_terminal_pos <= 0;
        wait_cyc(6);
        index_terminal_pos <= 1;
        wait_cyc(10);
        rd(8'h10);
        `CHK(d, 32'h00080001)
        wr(8'h0c, cnt + 3);
        mv(3);
        q.push_back({8'h01, cnt});
        wr(8'h10, 32'h0);
        wr(8'h0c, cnt + 2);
        mv(2);
        wr(8'h1c, 32'd47);
        wr(8'h14, 32'h60);
        dio_in[47] <= 0;
        wait_cyc(10);
        q.push_back({8'h20, cnt});
        dio_in[47] <= 1;
        wait_cyc(10);
        q.push_back({8'h40, cnt});
        rd(8'h24);
        `CHK(d, 32'h4)
        while (q.size() > 0)
            pop_check();
        `CHK(n_pulse, 4)
        wr(8'h00, 32'hd0);
        wr(8'h08, 32'h5a);
        peer_output <= 1;
        @(posedge sys_clk);
        peer_output <= 0;
        wait_cyc(4);
        rd(8'h04);
        `CHK(d, 32'h5a)
        wr(8'h20, 32'h1);
        wr(8'h10, 32'h00080008);
        wr(8'h00, 32'h94);
        wait_cyc(450);
        rd(8'h24);
        `CHK(d, 32'h1)
        rd(8'h40);
        `CHK(d, (cyc - 5) / 200)
        summarize();
    end
endmodule
